// ===== logic/afe_control_regs.sv
`timescale 1ns/1ns
// Operation
// - Long enable bits 6..4 power off aux DAC three, two, one.
// - Long enable bit 9 set powers the aux converter off.
// - Full duplex keeps both converters and both buses active.
// - Leaving full duplex for fast rx or fast tx uses fast recovery.
// - Trims decode as sign-magnitude, plus or minus 31, default zero.
// - Common-mode select codes 00..11 give 1.06, 0.94, 0.82, 0.71 V.
// - First chip-select pulse in shutdown is a wake request.
// - That rising edge enters the mode held in resume selector.
// - Resume selector codes 1..7: idle, standby, slow/fast rx/tx, duplex.
// - Writing zero to the resume selector is discarded.
// - Unwritten resume selector wakes into full duplex.
// - Aux converter config resets on, idle, 2.048 V, input one.
// - Reset: trims zero, common mode 00, short enable 111, resume 111.
// - Wake restores all settings; only the power mode changes.
// - Bits shifted during the wake pulse are ignored.
// - Sixteen bits MSB first, latched on chip-select rising edge.
module afe_control_regs
  import afe_pkg::*;
(
  input  wire logic         clock,
  input  wire logic         rstn,
  input  wire logic         csWakeN,
  input  wire logic         sclk,
  input  wire logic         din,
  output logic              rxAdcOn,
  output logic              rxBusOn,
  output logic              txDacOn,
  output logic              txBusOn,
  output logic              modeSettled,
  output logic [2:0]        powerMode,
  output logic [2:0]        auxDacOff,
  output logic              auxConverterOff,
  output logic signed [5:0] iTrimValue,
  output logic signed [5:0] qTrimValue,
  output logic [1:0]        commonLevel,
  output logic [10:0]       auxConfig,
  output logic [2:0]        resumeState
);

  // ---------------------------------------------------------------------
  // Functions
  // ---------------------------------------------------------------------
  function automatic logic signed [5:0] trim_decode(input logic [5:0] code);
    logic [5:0] mag;
    mag = {1'b0, code[4:0]};
    trim_decode = code[5] ? -$signed(mag) : $signed(mag);
  endfunction

  // Returns {rxAdc, rxBus, txDac, txBus}
  function automatic logic [3:0] mode_decode(input logic [2:0] mode);
    case (afe_mode_t'(mode))
      MODE_SLOW_RX:  mode_decode = 4'b1100;
      MODE_SLOW_TX:  mode_decode = 4'b0011;
      MODE_FAST_RX:  mode_decode = 4'b1110;
      MODE_FAST_TX:  mode_decode = 4'b1011;
      MODE_FULL_DUP: mode_decode = 4'b1111;
      default:       mode_decode = 4'b0000;
    endcase
  endfunction

  // ---------------------------------------------------------------------
  // Serial front end
  // ---------------------------------------------------------------------
  afe_frame_t frame;
  logic       frameFull;
  logic       csRise;

  afe_serial_rx u_rx (
    .clock     (clock),
    .rstn      (rstn),
    .csWakeN   (csWakeN),
    .sclk      (sclk),
    .din       (din),
    .frame     (frame),
    .frameFull (frameFull),
    .csRise    (csRise)
  );

  logic       inShutdown;
  logic       writeEn;
  logic       wakeEn;
  logic [5:0] iTrim_reg;
  logic [5:0] qTrim_reg;
  logic [2:0] mode_reg;
  logic [2:0] mode_next;

  assign inShutdown = (mode_reg == MODE_SHUTDOWN);
  assign wakeEn  = csRise && inShutdown;
  assign writeEn = csRise && !inShutdown && frameFull;

  // ---------------------------------------------------------------------
  // Setting registers
  // ---------------------------------------------------------------------
  // wake leaves these alone
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      iTrim_reg       <= RST_TRIM;
      qTrim_reg       <= RST_TRIM;
      commonLevel     <= RST_COMMON_MODE;
      auxConfig       <= RST_AUX_CONVERT;
      auxDacOff       <= RST_DAC_OFF;
      auxConverterOff <= RST_AUX_OFF;
    end else if (writeEn) begin
      case (frame.addr)
        ADDR_I_TRIM:      iTrim_reg   <= frame.data[5:0];
        ADDR_Q_TRIM:      qTrim_reg   <= frame.data[5:0];
        ADDR_COMMON_MODE: commonLevel <= frame.data[1:0];
        ADDR_AUX_CONVERT: auxConfig   <= frame.data[10:0];
        ADDR_ENABLE_LONG: begin
          auxDacOff       <= frame.data[POS_DAC_OFF_LO +: 3];
          auxConverterOff <= frame.data[POS_AUX_CONV_OFF];
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      iTrimValue <= 6'sh00;
      qTrimValue <= 6'sh00;
    end else begin
      iTrimValue <= trim_decode(iTrim_reg);
      qTrimValue <= trim_decode(qTrim_reg);
    end
  end

  // ---------------------------------------------------------------------
  // Resume state selector
  // ---------------------------------------------------------------------
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      resumeState <= RST_RESUME;
    end else if (writeEn && frame.addr == ADDR_RESUME_SEL) begin
      if (frame.data[2:0] != RESUME_INVALID)
        resumeState <= frame.data[2:0];
    end
  end

  // ---------------------------------------------------------------------
  // Power mode
  // ---------------------------------------------------------------------
  always_comb begin
    mode_next = mode_reg;
    if (wakeEn) begin
      mode_next = resumeState;
    end else if (writeEn) begin
      if (frame.addr == ADDR_ENABLE_LONG ||
          frame.addr == ADDR_ENABLE_SHORT)
        mode_next = frame.data[POS_MODE_LO +: 3];
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      mode_reg <= RST_MODE;
    end else begin
      mode_reg <= mode_next;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      {rxAdcOn, rxBusOn, txDacOn, txBusOn} <= 4'hf;
      powerMode <= RST_MODE;
    end else begin
      {rxAdcOn, rxBusOn, txDacOn, txBusOn} <= mode_decode(mode_reg);
      powerMode <= mode_reg;
    end
  end

  // ---------------------------------------------------------------------
  // Recovery timer
  // ---------------------------------------------------------------------
  // Only when both converters stay powered is the short settle enough
  logic [SETTLE_BITS-1:0] settleCount;
  logic [3:0]             oldPower;
  logic [3:0]             newPower;

  assign oldPower = mode_decode(mode_reg);
  assign newPower = mode_decode(mode_next);

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      settleCount <= '0;
      modeSettled <= 1'b1;
    end else if (mode_next != mode_reg) begin
      modeSettled <= 1'b0;
      // fast when both cores stay on
      if (oldPower[3] && oldPower[1] && newPower[3] && newPower[1])
        settleCount <= SETTLE_BITS'(FAST_RECOVERY_CYC - 1);
      else
        settleCount <= SETTLE_BITS'(SLOW_RECOVERY_CYC - 1);
    end else if (settleCount != '0) begin
      settleCount <= settleCount - 1'b1;
    end else begin
      modeSettled <= 1'b1;
    end
  end

endmodule

// ===== logic/afe_pkg.sv
package afe_pkg;

  // ---------------------------------------------------------------------
  // Serial frame layout
  // ---------------------------------------------------------------------
  localparam int FRAME_BITS = 16;
  localparam int ADDR_BITS  = 4;
  localparam int DATA_BITS  = 12;

  typedef struct packed {
    logic [ADDR_BITS-1:0] addr;
    logic [DATA_BITS-1:0] data;
  } afe_frame_t;

  // ---------------------------------------------------------------------
  // Register addresses (frame bits 15:12)
  // ---------------------------------------------------------------------
  localparam logic [3:0] ADDR_ENABLE_LONG  = 4'h0;
  localparam logic [3:0] ADDR_I_TRIM       = 4'h4;
  localparam logic [3:0] ADDR_Q_TRIM       = 4'h5;
  localparam logic [3:0] ADDR_COMMON_MODE  = 4'h6;
  localparam logic [3:0] ADDR_AUX_CONVERT  = 4'h7;
  localparam logic [3:0] ADDR_ENABLE_SHORT = 4'h8;
  localparam logic [3:0] ADDR_RESUME_SEL   = 4'h9;

  // Field positions inside the 12 data bits
  localparam int POS_AUX_CONV_OFF = 9;
  localparam int POS_DAC_OFF_LO   = 4;
  localparam int POS_MODE_LO      = 0;

  // ---------------------------------------------------------------------
  // Power modes
  // ---------------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_SHUTDOWN = 3'h0,
    MODE_IDLE     = 3'h1,
    MODE_STANDBY  = 3'h2,
    MODE_SLOW_RX  = 3'h3,
    MODE_SLOW_TX  = 3'h4,
    MODE_FAST_RX  = 3'h5,
    MODE_FAST_TX  = 3'h6,
    MODE_FULL_DUP = 3'h7
  } afe_mode_t;

  // ---------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------
  localparam logic [5:0]  RST_TRIM        = 6'h00;
  localparam logic [1:0]  RST_COMMON_MODE = 2'h0;
  localparam logic [10:0] RST_AUX_CONVERT = 11'h000;
  localparam logic [2:0]  RST_DAC_OFF     = 3'h0;
  localparam logic        RST_AUX_OFF     = 1'b0;
  localparam logic [2:0]  RST_MODE        = 3'h7;
  localparam logic [2:0]  RST_RESUME      = 3'h7;
  localparam logic [2:0]  RESUME_INVALID  = 3'h0;

  // ---------------------------------------------------------------------
  // Recovery timing
  // ---------------------------------------------------------------------
  localparam int CLK_PERIOD_NS     = 10;
  localparam int FAST_RECOVERY_NS  = 100;
  localparam int SLOW_RECOVERY_NS  = 4900;
  localparam int FAST_RECOVERY_CYC =
    (FAST_RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SLOW_RECOVERY_CYC =
    (SLOW_RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETTLE_BITS = 10;

endpackage

// ===== logic/afe_serial_rx.sv
`timescale 1ns/1ns
module afe_serial_rx
  import afe_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       rstn,
  input  wire logic       csWakeN,
  input  wire logic       sclk,
  input  wire logic       din,
  output afe_frame_t      frame,
  output logic            frameFull,
  output logic            csRise
);

  // ---------------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------------
  logic [1:0] csSync;
  logic [1:0] sclkSync;
  logic [1:0] dinSync;
  logic       csLast;
  logic       sclkLast;
  logic [4:0] bitCount;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      csSync   <= 2'h3;
      sclkSync <= 2'h0;
      dinSync  <= 2'h0;
      csLast   <= 1'b1;
      sclkLast <= 1'b0;
    end else begin
      csSync   <= {csSync[0], csWakeN};
      sclkSync <= {sclkSync[0], sclk};
      dinSync  <= {dinSync[0], din};
      csLast   <= csSync[1];
      sclkLast <= sclkSync[1];
    end
  end

  // ---------------------------------------------------------------------
  // Shift register
  // ---------------------------------------------------------------------
  // MSB first
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      frame    <= '0;
      bitCount <= 5'h00;
    end else if (csSync[1]) begin
      bitCount <= 5'h00;
    end else if (sclkSync[1] && !sclkLast) begin
      frame    <= {frame[FRAME_BITS-2:0], dinSync[1]};
      if (bitCount != 5'h1f)
        bitCount <= bitCount + 5'h01;
    end
  end

  assign frameFull = (bitCount == 5'(FRAME_BITS));
  assign csRise    = csSync[1] && !csLast;

endmodule

// ===== verif/afe_control_and_wakeup_regs_bench.sv
`timescale 1ns/1ns
module afe_control_and_wakeup_regs_bench
  import afe_pkg::*;
;
  typedef struct packed {
    logic [15:0] word;
    logic [2:0]  sel;
    logic [10:0] exp;
  } afe_row_t;
  logic              clock, rstn, csWakeN, sclk, din, rxAdcOn, rxBusOn;
  logic              txDacOn, txBusOn, modeSettled, auxConverterOff;
  logic [2:0]        powerMode, auxDacOff, resumeState;
  logic signed [5:0] iTrimValue, qTrimValue;
  logic [1:0]        commonLevel;
  logic [10:0]       auxConfig;
  int                nMismatch, totalChecks;
  afe_row_t rows [24] = '{
    '{16'h401f, 3'h0, 11'h01f}, '{16'h403f, 3'h0, 11'h021},
    '{16'h4020, 3'h0, 11'h000}, '{16'h5021, 3'h1, 11'h03f},
    '{16'h5005, 3'h1, 11'h005}, '{16'h6000, 3'h2, 11'h000},
    '{16'h6001, 3'h2, 11'h001}, '{16'h6002, 3'h2, 11'h002},
    '{16'h6003, 3'h2, 11'h003}, '{16'h77ff, 3'h3, 11'h7ff},
    '{16'hf123, 3'h3, 11'h7ff}, '{16'h0207, 3'h4, 11'h008},
    '{16'h0057, 3'h4, 11'h005}, '{16'h0067, 3'h4, 11'h006},
    '{16'h0017, 3'h4, 11'h001}, '{16'h0027, 3'h4, 11'h002},
    '{16'h0077, 3'h4, 11'h007}, '{16'h0007, 3'h4, 11'h000},
    '{16'h8005, 3'h5, 11'h005}, '{16'h8003, 3'h5, 11'h003},
    '{16'h0006, 3'h5, 11'h006}, '{16'h8007, 3'h5, 11'h007},
    '{16'h9005, 3'h6, 11'h005}, '{16'h9000, 3'h6, 11'h005}};
  // Per mode {rxAdc, rxBus, txDac, txBus}, from the mode table
  logic [3:0]        pwrExp [8] = '{4'h0, 4'h0, 4'h0, 4'hc,
                                    4'h3, 4'he, 4'hb, 4'hf};
  afe_serial_host u_afe_serial_host (.clock(clock), .csWakeN(csWakeN),
    .sclk(sclk), .din(din));
  afe_control_regs u_afe_control_regs (.clock(clock), .rstn(rstn),
    .csWakeN(csWakeN), .sclk(sclk), .din(din), .rxAdcOn(rxAdcOn),
    .rxBusOn(rxBusOn), .txDacOn(txDacOn), .txBusOn(txBusOn),
    .modeSettled(modeSettled), .powerMode(powerMode),
    .auxDacOff(auxDacOff), .auxConverterOff(auxConverterOff),
    .iTrimValue(iTrimValue), .qTrimValue(qTrimValue),
    .commonLevel(commonLevel), .auxConfig(auxConfig),
    .resumeState(resumeState));
  function automatic logic [10:0] obs(input logic [2:0] sel);
    case (sel)
      3'h0: obs = {5'h00, iTrimValue};
      3'h1: obs = {5'h00, qTrimValue};
      3'h2: obs = {9'h000, commonLevel};
      3'h3: obs = auxConfig;
      3'h4: obs = {7'h00, auxConverterOff, auxDacOff};
      3'h5: obs = {8'h00, powerMode};
      3'h7: obs = {7'h00, rxAdcOn, rxBusOn, txDacOn, txBusOn};
      default: obs = {8'h00, resumeState};
    endcase
  endfunction
  task automatic check(input logic [10:0] got, input logic [10:0] exp);
    totalChecks++;
    if (got !== exp) begin
      nMismatch++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic endSim();
    if (nMismatch == 0 && totalChecks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Alternate prompt and slow serial timing; result lands by T+5
  task automatic frame(input logic [15:0] w, input int n);
    u_afe_serial_host.send(w, n, 3 + (totalChecks % 2) * 3);
    repeat (8) @(posedge clock);
  endtask
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial begin
    repeat (100000) @(posedge clock);
    nMismatch++;
    endSim();
  end
  initial begin
    rstn = 1'b0;
    repeat (3) @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
    for (int s = 0; s < 7; s++)
      check(obs(3'(s)), (s > 4) ? 11'h007 : 11'h000);
    check(obs(3'h7), 11'h00f);
    foreach (rows[r]) begin
      frame(rows[r].word, 16);
      check(obs(rows[r].sel), rows[r].exp);
    end
    for (int k = 1; k < 8; k++) begin
      frame(16'h9000 | 16'(k), 16);
      frame(16'h8000, 16);
      check(obs(3'h5), 11'h000);
      frame(16'h403c, 16);
      check(obs(3'h5), 11'(k));
      check(obs(3'h7), 11'(pwrExp[k]));
      check(obs(3'h0), 11'h000);
    end
    frame(16'h4011, 15);
    frame(16'h4011, 17);
    check(obs(3'h0), 11'h000);
    // Move the selector off its reset code so the reset is visible
    frame(16'h9003, 16);
    check(obs(3'h6), 11'h003);
    rstn <= 1'b0;
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
    check(obs(3'h6), 11'h007);
    check(obs(3'h3), 11'h000);
    // Selector untouched since reset: wake must land in full duplex
    frame(16'h8000, 16);
    frame(16'h4015, 16);
    check(obs(3'h5), 11'h007);
    check(obs(3'h0), 11'h000);
    endSim();
  end
endmodule

// ===== verif/afe_control_regs_sva.sv
`timescale 1ns/1ns
module afe_control_regs_sva
  import afe_pkg::*;
(
  input wire logic               clock,
  input wire logic               rstn,
  input wire logic               csWakeN,
  input wire logic               rxAdcOn,
  input wire logic               rxBusOn,
  input wire logic               txDacOn,
  input wire logic               txBusOn,
  input wire logic               modeSettled,
  input wire logic [2:0]         powerMode,
  input wire logic signed [5:0]  iTrimValue,
  input wire logic [1:0]         commonLevel,
  input wire logic [10:0]        auxConfig,
  input wire logic [2:0]         resumeState
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  sequence wakeEdge;
    powerMode == 3'h0 && $rose(csWakeN);
  endsequence
  sequence leaveDuplex;
    $past(powerMode) == 3'h7 && powerMode inside {3'h5, 3'h6};
  endsequence
  a_duplex_all_on: assert property (powerMode == 3'h7 |->
    rxAdcOn && rxBusOn && txDacOn && txBusOn) else $error("duplex off");
  a_slow_rx_power: assert property (powerMode == 3'h3 |->
    rxAdcOn && rxBusOn && !txDacOn && !txBusOn) else $error("slow rx");
  a_fast_settle: assert property (leaveDuplex |->
    ##[1:12] modeSettled) else $error("slow recovery");
  a_wake_mode: assert property (wakeEdge |->
    ##[3:5] powerMode == resumeState) else $error("wrong wake mode");
  a_resume_nonzero: assert property (
    resumeState != 3'h0) else $error("resume zero");
  a_trim_range: assert property (
    iTrimValue != 6'sh20) else $error("trim out of range");
  a_cfg_hold_low: assert property (!csWakeN [*8] |=>
    $stable(resumeState) && $stable(iTrimValue) && $stable(auxConfig))
    else $error("change mid frame");
  a_sleep_keeps: assert property (
    powerMode == 3'h0 && $past(powerMode) == 3'h0 |=>
    $stable(iTrimValue) && $stable(commonLevel) && $stable(auxConfig))
    else $error("setting lost");
endmodule
bind afe_control_regs afe_control_regs_sva u_afe_control_regs_sva (
  .clock(clock), .rstn(rstn), .csWakeN(csWakeN), .rxAdcOn(rxAdcOn),
  .rxBusOn(rxBusOn), .txDacOn(txDacOn), .txBusOn(txBusOn),
  .modeSettled(modeSettled), .powerMode(powerMode),
  .iTrimValue(iTrimValue), .commonLevel(commonLevel),
  .auxConfig(auxConfig), .resumeState(resumeState));

// ===== verif/afe_serial_host.sv
`timescale 1ns/1ns
module afe_serial_host (
  input  wire logic clock,
  output logic      csWakeN,
  output logic      sclk,
  output logic      din
);
  initial begin
    csWakeN = 1'b1;
    sclk    = 1'b0;
    din     = 1'b0;
  end
  // MSB first
  // Bit count is free so the bench can send torn frames
  task automatic send(input logic [15:0] w, input int n, input int half);
    @(posedge clock);
    csWakeN <= 1'b0;
    for (int i = 0; i < n; i++) begin
      din <= w[15-(i%16)];
      repeat (half) @(posedge clock);
      sclk <= 1'b1;
      repeat (half) @(posedge clock);
      sclk <= 1'b0;
    end
    repeat (half) @(posedge clock);
    csWakeN <= 1'b1;
    // No pull on the data line: show junk once released
    din <= ~din;
    repeat (4) @(posedge clock);
  endtask
endmodule
